//--- eqrs_pkg.sv
// Constants, register map and carrier types of the egress queue rate scheduler.
package eqrs_pkg;
  localparam int unsigned NUM_PORTS  = 2;
  localparam int unsigned NUM_QUEUES = 4;
  localparam int unsigned RATIO_W    = 7;
  localparam int unsigned REG_W      = 16;
  localparam int unsigned ADDR_W     = 12;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [ADDR_W-1:0] IDX_P1_HIGH = 12'h00c8;
  localparam logic [ADDR_W-1:0] IDX_P1_LOW  = 12'h00ca;
  localparam logic [ADDR_W-1:0] IDX_P2_HIGH = 12'h00cc;
  localparam logic [ADDR_W-1:0] IDX_P2_LOW  = 12'h00ce;
  localparam logic [ADDR_W-1:0] ADDR_P1_HIGH = IDX_P1_HIGH << 2;
  localparam logic [ADDR_W-1:0] ADDR_P1_LOW  = IDX_P1_LOW << 2;
  localparam logic [ADDR_W-1:0] ADDR_P2_HIGH = IDX_P2_HIGH << 2;
  localparam logic [ADDR_W-1:0] ADDR_P2_LOW  = IDX_P2_LOW << 2;
  // Read-only allowance status, one word per port.
  localparam logic [ADDR_W-1:0] ADDR_P1_ALLOW = 12'h0400;
  localparam logic [ADDR_W-1:0] ADDR_P2_ALLOW = 12'h0404;

  // Field layout inside each 16-bit rate register and the allowance status word.
  localparam int unsigned UPPER_MODE_BIT  = 15;
  localparam int unsigned UPPER_RATIO_LSB = 8;
  localparam int unsigned LOWER_MODE_BIT  = 7;
  localparam int unsigned LOWER_RATIO_LSB = 0;
  localparam int unsigned ALLOW_STRIDE    = 8;

  // Reset values: all queues in ratio mode, q2 = 4, q3 = 8, q0 = 1, q1 = 2.
  localparam logic [REG_W-1:0] HIGH_RST = 16'h8488;
  localparam logic [REG_W-1:0] LOW_RST  = 16'h8182;

  // Scheduling period.
  localparam int unsigned CLK_MHZ       = 25;
  localparam int unsigned PERIOD_US     = 100;
  localparam int unsigned PERIOD_CYCLES = PERIOD_US * CLK_MHZ;

  typedef struct packed {
    logic [NUM_QUEUES-1:0] nonempty;
    logic                  tx_req;
  } eqrs_port_req_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] queue;
  } eqrs_grant_t;
endpackage

//--- eqrs_sched.sv
// Egress queue rate scheduler for switch ports 1 and 2 with its APB register file.
//
// Behaviour
// - First register holds queue 2 and 3 settings.
// - Queue 2 mode bit 15; strict beats lower.
// - Queue 2 ratio bits 14:8, reset 4.
// - Queue 3 mode bit 7; strict drains first.
// - Queue 3 ratio bits 6:0, reset 8.
// - Second register holds queue 0 and 1 settings.
// - Queue 0 mode bit 15; strict lowest priority.
// - Queue 0 ratio bits 14:8, reset 1.
// - Queue 1 mode bit 7; strict before queue 0.
// - Queue 1 ratio bits 6:0, reset 2.
module eqrs_sched #(
  parameter int unsigned PERIOD_CYCLES = eqrs_pkg::PERIOD_CYCLES
) (
  // Clock and reset.
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  // APB slave.
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [eqrs_pkg::ADDR_W-1:0]       paddr,
  input  wire logic [31:0]                       pwdata,
  input  wire logic [3:0]                        pstrb,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // Per-port queue state and grants.
  input  eqrs_pkg::eqrs_port_req_t               port_req [eqrs_pkg::NUM_PORTS],
  output eqrs_pkg::eqrs_grant_t                  grant    [eqrs_pkg::NUM_PORTS]
);
  localparam int unsigned NP  = eqrs_pkg::NUM_PORTS;
  localparam int unsigned NQ  = eqrs_pkg::NUM_QUEUES;
  localparam int unsigned RW  = eqrs_pkg::RATIO_W;
  localparam int unsigned PCW = (PERIOD_CYCLES > 1) ? $clog2(PERIOD_CYCLES) : 1;
  localparam logic [PCW-1:0] PERIOD_LAST = PCW'(PERIOD_CYCLES - 1);

  if (PERIOD_CYCLES < 2) begin : g_period_check
    $error("PERIOD_CYCLES must be at least 2");
  end

  // Mode bit of a queue: 1 is ratio mode, 0 is strict priority.
  function automatic logic queue_ratio_mode(input logic [15:0] hi, input logic [15:0] lo, input int q);
    unique case (q)
      0:       return lo[eqrs_pkg::UPPER_MODE_BIT];
      1:       return lo[eqrs_pkg::LOWER_MODE_BIT];
      2:       return hi[eqrs_pkg::UPPER_MODE_BIT];
      default: return hi[eqrs_pkg::LOWER_MODE_BIT];
    endcase
  endfunction

  // Packet allowance of a queue per period.
  function automatic logic [6:0] queue_ratio(input logic [15:0] hi, input logic [15:0] lo, input int q);
    unique case (q)
      0:       return lo[eqrs_pkg::UPPER_RATIO_LSB +: 7];
      1:       return lo[eqrs_pkg::LOWER_RATIO_LSB +: 7];
      2:       return hi[eqrs_pkg::UPPER_RATIO_LSB +: 7];
      default: return hi[eqrs_pkg::LOWER_RATIO_LSB +: 7];
    endcase
  endfunction

  // Highest-numbered eligible queue wins; bit 2 of the result flags a winner.
  function automatic logic [2:0] pick_queue(input logic [3:0] elig);
    logic [2:0] res;
    res = 3'h0;
    for (int q = 0; q < 4; q++) begin
      if (elig[q]) begin
        res = {1'b1, 2'(q)};
      end
    end
    return res;
  endfunction

  logic [15:0]    high_r    [NP];
  logic [15:0]    high_nxt  [NP];
  logic [15:0]    low_r     [NP];
  logic [15:0]    low_nxt   [NP];
  logic [RW-1:0]  allow_r   [NP][NQ];
  logic [RW-1:0]  allow_nxt [NP][NQ];
  logic [PCW-1:0] period_r;
  logic [PCW-1:0] period_nxt;
  logic           period_end;
  logic [NQ-1:0]  elig      [NP];
  eqrs_pkg::eqrs_grant_t grant_r   [NP];
  eqrs_pkg::eqrs_grant_t grant_nxt [NP];
  logic [31:0]    prdata_r;
  logic [31:0]    prdata_nxt;
  logic           pready_r;
  logic           pready_nxt;
  logic           pslverr_r;
  logic           pslverr_nxt;
  logic           wr_en;
  logic           setup;

  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pready_r && pwrite;
  assign period_end = (period_r == PERIOD_LAST);

  // Register file: byte lanes 0 and 1 carry the 16-bit rate registers.
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      high_nxt[p] = high_r[p];
      low_nxt[p]  = low_r[p];
    end
    if (wr_en) begin
      for (int p = 0; p < NP; p++) begin
        if (paddr == ((p == 0) ? eqrs_pkg::ADDR_P1_HIGH : eqrs_pkg::ADDR_P2_HIGH)) begin
          if (pstrb[0]) high_nxt[p][7:0]  = pwdata[7:0];
          if (pstrb[1]) high_nxt[p][15:8] = pwdata[15:8];
        end
        if (paddr == ((p == 0) ? eqrs_pkg::ADDR_P1_LOW : eqrs_pkg::ADDR_P2_LOW)) begin
          if (pstrb[0]) low_nxt[p][7:0]  = pwdata[7:0];
          if (pstrb[1]) low_nxt[p][15:8] = pwdata[15:8];
        end
      end
    end
  end

  // Read data and answer are prepared in the setup cycle; every access takes one access cycle.
  always_comb begin
    prdata_nxt  = prdata_r;
    pready_nxt  = setup;
    pslverr_nxt = 1'b0;
    if (setup) begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        eqrs_pkg::ADDR_P1_HIGH:  prdata_nxt[15:0] = high_r[0];
        eqrs_pkg::ADDR_P1_LOW:   prdata_nxt[15:0] = low_r[0];
        eqrs_pkg::ADDR_P2_HIGH:  prdata_nxt[15:0] = high_r[1];
        eqrs_pkg::ADDR_P2_LOW:   prdata_nxt[15:0] = low_r[1];
        eqrs_pkg::ADDR_P1_ALLOW, eqrs_pkg::ADDR_P2_ALLOW: begin
          for (int q = 0; q < NQ; q++) begin
            prdata_nxt[q*eqrs_pkg::ALLOW_STRIDE +: RW] = allow_r[(paddr == eqrs_pkg::ADDR_P1_ALLOW) ? 0 : 1][q];
          end
        end
        default:                 pslverr_nxt = 1'b1;
      endcase
    end
  end

  // Period counter and per-port arbitration.
  always_comb begin
    period_nxt = period_end ? '0 : period_r + PCW'(1);
    for (int p = 0; p < NP; p++) begin
      logic [2:0] win;
      win = 3'h0;
      for (int q = 0; q < NQ; q++) begin
        // A nonempty strict queue is always eligible; a ratio queue only while allowance remains.
        elig[p][q] = port_req[p].nonempty[q] &&
                     (!queue_ratio_mode(high_r[p], low_r[p], q) || allow_r[p][q] != '0);
      end
      win = pick_queue(elig[p]);
      grant_nxt[p].valid = port_req[p].tx_req && win[2];
      grant_nxt[p].queue = win[1:0];
      for (int q = 0; q < NQ; q++) begin
        if (period_end) begin
          allow_nxt[p][q] = queue_ratio(high_r[p], low_r[p], q);
        end else if (grant_nxt[p].valid && grant_nxt[p].queue == 2'(q) &&
                     queue_ratio_mode(high_r[p], low_r[p], q)) begin
          allow_nxt[p][q] = allow_r[p][q] - RW'(1);
        end else begin
          allow_nxt[p][q] = allow_r[p][q];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_r  <= '0;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      for (int p = 0; p < NP; p++) begin
        high_r[p]  <= eqrs_pkg::HIGH_RST;
        low_r[p]   <= eqrs_pkg::LOW_RST;
        grant_r[p] <= '0;
        allow_r[p][0] <= eqrs_pkg::LOW_RST[eqrs_pkg::UPPER_RATIO_LSB +: 7];
        allow_r[p][1] <= eqrs_pkg::LOW_RST[eqrs_pkg::LOWER_RATIO_LSB +: 7];
        allow_r[p][2] <= eqrs_pkg::HIGH_RST[eqrs_pkg::UPPER_RATIO_LSB +: 7];
        allow_r[p][3] <= eqrs_pkg::HIGH_RST[eqrs_pkg::LOWER_RATIO_LSB +: 7];
      end
    end else begin
      period_r  <= period_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      for (int p = 0; p < NP; p++) begin
        high_r[p]  <= high_nxt[p];
        low_r[p]   <= low_nxt[p];
        grant_r[p] <= grant_nxt[p];
        allow_r[p] <= allow_nxt[p];
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  for (genvar g = 0; g < NP; g++) begin : g_out
    assign grant[g] = grant_r[g];
  end

  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence apb_access_s;
    psel && penable;
  endsequence

  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup_s ##1 apb_access_s |-> pready)
    else $error("APB access not answered in its first access cycle");

  period_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
    period_end |=> (period_r == '0) && (allow_r[0][3] == $past(high_r[0][6:0]))
                   && (allow_r[1][0] == $past(low_r[1][14:8])))
    else $error("allowance not reloaded at period end");

  for (genvar g = 0; g < NP; g++) begin : g_chk
    high_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && pstrb[1:0] == 2'b11 && paddr == ((g == 0) ? eqrs_pkg::ADDR_P1_HIGH : eqrs_pkg::ADDR_P2_HIGH)
      |=> high_r[g] == $past(pwdata[15:0]))
      else $error("first rate register write lost");

    low_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && pstrb[1:0] == 2'b11 && paddr == ((g == 0) ? eqrs_pkg::ADDR_P1_LOW : eqrs_pkg::ADDR_P2_LOW)
      |=> low_r[g] == $past(pwdata[15:0]))
      else $error("second rate register write lost");

    strict_q3_a: assert property (@(posedge pclk) disable iff (!presetn)
      port_req[g].tx_req && port_req[g].nonempty[3] && !high_r[g][7]
      |=> grant_r[g].valid && grant_r[g].queue == 2'd3)
      else $error("strict queue 3 not served first");

    strict_q2_a: assert property (@(posedge pclk) disable iff (!presetn)
      grant_r[g].valid && grant_r[g].queue < 2'd2 |-> !$past(port_req[g].nonempty[2] && !high_r[g][15]))
      else $error("lower queue sent ahead of strict queue 2");

    strict_q1_a: assert property (@(posedge pclk) disable iff (!presetn)
      grant_r[g].valid && grant_r[g].queue == 2'd0 |-> !$past(port_req[g].nonempty[1] && !low_r[g][7]))
      else $error("queue 0 sent ahead of strict queue 1");

    q0_last_a: assert property (@(posedge pclk) disable iff (!presetn)
      grant_r[g].valid && grant_r[g].queue == 2'd0 |-> $past(elig[g][3:1]) == 3'b000)
      else $error("queue 0 served while a higher queue was eligible");

    // One copy per queue, so that the sampled past is always taken for the queue granted now.
    for (genvar q = 0; q < NQ; q++) begin : g_q
      exhausted_yield_a: assert property (@(posedge pclk) disable iff (!presetn)
        grant_r[g].valid && grant_r[g].queue == 2'(q)
        |-> !$past(queue_ratio_mode(high_r[g], low_r[g], q) && allow_r[g][q] == '0))
        else $error("exhausted ratio queue was granted");

      allow_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        grant_r[g].valid && grant_r[g].queue == 2'(q) && !$past(period_end)
        && $past(queue_ratio_mode(high_r[g], low_r[g], q))
        |-> allow_r[g][q] == $past(allow_r[g][q]) - RW'(1))
        else $error("ratio grant did not use one allowance");
    end
  end
endmodule

//--- eqrs_sched_test.sv
// Self-checking testbench of the egress queue rate scheduler.
module eqrs_sched_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                           pclk = 1'b0;
  logic                           presetn = 1'b0;
  logic                           psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [eqrs_pkg::ADDR_W-1:0]    paddr = '0;
  logic [31:0]                    pwdata = '0, prdata;
  logic [3:0]                     pstrb = 4'h3;
  logic                           pready, pslverr;
  eqrs_pkg::eqrs_port_req_t       req [eqrs_pkg::NUM_PORTS] = '{default: '0};
  eqrs_pkg::eqrs_grant_t          grant [eqrs_pkg::NUM_PORTS];
  int                             num_errors = 0;
  int                             n_compared = 0;
  logic [31:0]                    rd;
  logic                           err;

  always #20 pclk = ~pclk;

  eqrs_sched #(.PERIOD_CYCLES(100)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_req(req), .grant(grant));

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t bus answer missing", $time);
      final_report();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic test_reset_map();
    do_reset();
    apb(1'b0, eqrs_pkg::ADDR_P1_HIGH, '0); chk(rd, 32'h0000_8488, "p1 high reset");
    apb(1'b0, eqrs_pkg::ADDR_P1_LOW, '0);  chk(rd, 32'h0000_8182, "p1 low reset");
    apb(1'b0, eqrs_pkg::ADDR_P2_HIGH, '0); chk(rd, 32'h0000_8488, "p2 high reset");
    apb(1'b0, eqrs_pkg::ADDR_P2_LOW, '0);  chk(rd, 32'h0000_8182, "p2 low reset");
    apb(1'b0, eqrs_pkg::ADDR_P2_ALLOW, '0); chk(rd, 32'h0804_0201, "p2 allowance reset");
    apb(1'b1, 12'h010, 32'h0000_ffff); chk({31'h0, err}, 32'h1, "unmapped write error");
    apb(1'b0, 12'h010, '0); chk({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
    $display("test reset_map done");
  endtask

  // Reset, optionally program one register, request for cyc cycles and count grants per queue.
  task automatic run_case(input string name, input logic [11:0] a, input logic [15:0] d, input logic [3:0] ne0,
                          input logic [3:0] ne1, input int cyc, input logic [31:0] e0, input logic [31:0] e1);
    logic [7:0] cnt [2][4];
    logic [1:0] last [2];
    cnt = '{default: '0};
    last = '{2'd3, 2'd3};
    do_reset();
    if (a != '0) begin
      apb(1'b1, a, {16'h0, d});
      apb(1'b0, a, '0); chk(rd, {16'h0, d}, "readback");
    end
    @(posedge pclk);
    req[0] <= '{nonempty: ne0, tx_req: 1'b1};
    req[1] <= '{nonempty: ne1, tx_req: 1'b1};
    for (int c = 0; c < cyc + 2; c++) begin
      @(posedge pclk);
      if (c == cyc - 1) begin
        req[0] <= '0;
        req[1] <= '0;
      end
      for (int p = 0; p < 2; p++) begin
        if (grant[p].valid === 1'b1) begin
          cnt[p][grant[p].queue]++;
          chk({31'h0, grant[p].queue > last[p]}, 32'h0, "grant order");
          last[p] = grant[p].queue;
        end
      end
    end
    chk({cnt[0][3], cnt[0][2], cnt[0][1], cnt[0][0]}, e0, "port1 counts");
    chk({cnt[1][3], cnt[1][2], cnt[1][1], cnt[1][0]}, e1, "port2 counts");
    $display("test %s done", name);
  endtask

  initial begin
    test_reset_map();
    run_case("ratios", '0, '0, 4'hf, 4'h4, 40, 32'h0804_0201, 32'h0004_0000);
    apb(1'b0, eqrs_pkg::ADDR_P1_ALLOW, '0); chk(rd, 32'h0, "p1 allowance spent");
    run_case("q3_strict", eqrs_pkg::ADDR_P1_HIGH, 16'h8408, 4'hf, 4'h0, 40, 32'h2800_0000, 32'h0);
    run_case("q2_strict", eqrs_pkg::ADDR_P1_HIGH, 16'h0488, 4'h7, 4'h0, 40, 32'h0028_0000, 32'h0);
    run_case("q1_strict", eqrs_pkg::ADDR_P1_LOW, 16'h8102, 4'h3, 4'h0, 40, 32'h0000_2800, 32'h0);
    run_case("q0_strict", eqrs_pkg::ADDR_P1_LOW, 16'h0182, 4'hf, 4'hf, 40, 32'h0804_021a, 32'h0804_0201);
    run_case("p2_low_reload", eqrs_pkg::ADDR_P2_LOW, 16'h8380, 4'h0, 4'h3, 130, 32'h0, 32'h0000_0204);
    run_case("q3_reload", '0, '0, 4'h8, 4'h0, 150, 32'h1000_0000, 32'h0);
    final_report();
  end
endmodule
